/* hw/ssp_pkg.sv */
// Package: register map, field positions and constants of the serial shift port
`default_nettype none
package ssp_pkg;
  // Register byte offsets (AXI4-Lite, one aligned word each)
  localparam logic [7:0] REG_CTRL_OFS   = 8'h00;
  localparam logic [7:0] REG_STATUS_OFS = 8'h04;
  localparam logic [7:0] REG_SHIFT_OFS  = 8'h08;
  localparam logic [7:0] REG_PORTCFG_OFS = 8'h0C;
  // Control register fields
  localparam int CTRL_RATE_LO_BIT = 0;
  localparam int CTRL_RATE_HI_BIT = 1;
  localparam int CTRL_ENABLE_BIT  = 2;
  // Status register fields
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_IEN_BIT     = 1;
  localparam int STAT_DONE_BIT    = 2;
  localparam int STAT_SKLVL_BIT   = 3;
  // Port configuration fields
  localparam int CFG_PIN4_BIT     = 4;
  localparam int CFG_PIN5_BIT     = 5;
  localparam int CFG_PIN6_BIT     = 6;
  // Reset values
  localparam logic [2:0] CTRL_RESET    = 3'h0;
  localparam logic [6:4] PORTCFG_RESET = 3'h0;
  localparam logic [7:0] SHIFT_RESET   = 8'h00;
  // Half-period counts of the shift clock in instruction cycles
  localparam logic [2:0] HALF_RATE0 = 3'h1;
  localparam logic [2:0] HALF_RATE1 = 3'h2;
  localparam logic [2:0] HALF_RATE2 = 3'h4;
  // Bits per transfer
  localparam logic [3:0] XFER_BITS = 4'h8;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Clock and instruction cycle
  localparam int MCLK_HZ      = 25_000_000;
  localparam int INSTR_NS     = 1000;
  localparam int MCLK_NS      = 40;
  localparam int INSTR_CYCLES = (INSTR_NS + MCLK_NS - 1) / MCLK_NS;
  // Helper: half period of the master shift clock from rate bits
  function automatic logic [2:0] half_count(input logic hi, input logic lo);
    if (hi) begin
      half_count = HALF_RATE2;
    end else if (lo) begin
      half_count = HALF_RATE1;
    end else begin
      half_count = HALF_RATE0;
    end
  endfunction : half_count
endpackage : ssp_pkg
`default_nettype wire

/* hw/ssp_shifter.sv */
// Module: eight-bit shift engine driven by clock edge strobes
`default_nettype none
module ssp_shifter
  import ssp_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Control
  input  wire logic       i_active,
  input  wire logic       i_alt_phase,
  input  wire logic       i_rise,
  input  wire logic       i_fall,
  input  wire logic       i_sdi,
  input  wire logic       i_load,
  input  wire logic [7:0] i_load_data,
  // Results
  output logic [7:0]      o_data,
  output logic            o_sdo,
  output logic            o_done
);
  logic [7:0] data_q, data_d;
  logic       samp_q, samp_d;
  logic       sdo_q, sdo_d;
  logic [3:0] cnt_q, cnt_d;
  logic       done_d;
  logic       samp_edge, drive_edge;

  // Sample and drive edges per phase
  always_comb begin
    samp_edge  = i_alt_phase ? i_fall : i_rise;
    drive_edge = i_alt_phase ? i_rise : i_fall;
  end

  // Next-state of the shift engine
  always_comb begin
    data_d = data_q;
    samp_d = samp_q;
    sdo_d  = sdo_q;
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (i_load) begin
      data_d = i_load_data;
      sdo_d  = i_load_data[7];
      cnt_d  = 4'h0;
    end else if (!i_active) begin
      cnt_d = 4'h0;
      sdo_d = data_q[7];
    end else begin
      if (samp_edge) begin
        samp_d = i_sdi;
      end
      // alternate phase drives top bit on rise
      if (i_alt_phase && drive_edge) begin
        sdo_d = data_q[7];
      end
      // shift on falling edge in both phases
      // Falling edge ends each bit, so the eighth bit lands in the same cycle as done
      if (i_fall) begin
        data_d = {data_q[6:0], (i_alt_phase ? i_sdi : samp_q)};
        cnt_d  = cnt_q + 4'h1;
        if (!i_alt_phase) begin
          sdo_d = data_q[6];
        end
        if (cnt_q + 4'h1 == XFER_BITS) begin
          done_d = 1'b1;
        end
      end
    end
  end

  // Engine registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      data_q <= SHIFT_RESET;
      samp_q <= 1'b0;
      sdo_q  <= 1'b0;
      cnt_q  <= 4'h0;
      o_done <= 1'b0;
    end else begin
      data_q <= data_d;
      samp_q <= samp_d;
      sdo_q  <= sdo_d;
      cnt_q  <= cnt_d;
      o_done <= done_d;
    end
  end

  assign o_data = data_q;
  assign o_sdo  = sdo_q;
endmodule : ssp_shifter
`default_nettype wire

/* hw/ssp_top.sv */
// Module: serial shift port with AXI4-Lite registers
`default_nettype none
// What this block does
// - Eight-bit shift register with data in, data out and shift clock pins.
// - Master makes the shift clock; slave takes it from outside.
// - Port works only when enable bit set; enable routes pins.
// - Master rate: 00 two, 01 four, 1x eight instruction cycles.
// - Setting busy starts shifting; hardware clears busy after eight bits.
// - Software clearing busy stops shifting early.
// - Completion raises interrupt request when enabled.
// - Shift clock rests low when no transfer runs.
// - Master starts every exchange; slave never starts alone.
// - Pin five config picks master or slave; pin four off floats output.
// - Normal phase samples on rise, drives on fall.
// - Normal phase shifts register on each falling edge.
// - Alternate phase samples on fall, drives on rise.
// - Phase flag in pin six config bit selects alternate phase.
// - Phase flag resets cleared, normal phase.
module ssp_top
  import ssp_pkg::*;
(
  // Clock and reset
  input  wire logic        I_MCLK,
  input  wire logic        I_RST,
  // AXI4-Lite write address
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [7:0]  I_AWADDR,
  // AXI4-Lite write data
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  // AXI4-Lite write response
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  output logic [1:0]       O_BRESP,
  // AXI4-Lite read address
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  input  wire logic [7:0]  I_ARADDR,
  // AXI4-Lite read data
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  // Serial pins
  input  wire logic        I_SDI,
  input  wire logic        I_SHIFT_CLOCK_PIN,
  output logic             O_SHIFT_CLOCK_PIN,
  output logic             O_SHIFT_CLOCK_PIN_OE_N,
  output logic             O_SDO,
  output logic             O_SDO_OE_N,
  // Completion request
  output logic             O_IRQ
);
  // Control and status state
  logic [2:0] ctrl_q, ctrl_d;
  logic [6:4] cfg_q, cfg_d;
  logic       busy_q, busy_d;
  logic       ien_q, ien_d;
  logic       done_q, done_d;
  logic       irq_q, irq_d;
  // Bus state
  logic       aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0] ws_q, ws_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  // Link clock sampling and generator
  logic       sk_s1_q, sk_s2_q, sk_s3_q;
  logic       sdi_s1_q, sdi_s2_q;
  logic [4:0] tc_q, tc_d;
  logic [2:0] hc_q, hc_d;
  logic       skm_q, skm_d;
  logic       tick;
  // Derived
  logic       enabled, master, active, sk_lvl, rise, fall;
  logic       wr_go, load, done_pulse;
  logic [7:0] shift_data;
  logic       sdo_w;

  // Two-stage synchronisers for pin inputs
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      sk_s1_q  <= 1'b0;
      sk_s2_q  <= 1'b0;
      sk_s3_q  <= 1'b0;
      sdi_s1_q <= 1'b0;
      sdi_s2_q <= 1'b0;
    end else begin
      sk_s1_q  <= I_SHIFT_CLOCK_PIN;
      sk_s2_q  <= sk_s1_q;
      sk_s3_q  <= sk_s2_q;
      sdi_s1_q <= I_SDI;
      sdi_s2_q <= sdi_s1_q;
    end
  end

  // Mode decode
  always_comb begin
    enabled = ctrl_q[CTRL_ENABLE_BIT];
    master  = enabled && cfg_q[CFG_PIN5_BIT];
    active  = enabled && busy_q;
    tick    = (tc_q == 5'(INSTR_CYCLES - 1));
  end

  // Instruction cycle divider and master clock generator
  always_comb begin
    tc_d  = tick ? 5'h0 : tc_q + 5'h1;
    hc_d  = hc_q;
    skm_d = skm_q;
    if (!(master && active)) begin
      skm_d = 1'b0;
      hc_d  = 3'h0;
    end else if (tick) begin
      if (hc_q + 3'h1 >= half_count(ctrl_q[CTRL_RATE_HI_BIT], ctrl_q[CTRL_RATE_LO_BIT])) begin
        hc_d  = 3'h0;
        skm_d = ~skm_q;
      end else begin
        hc_d = hc_q + 3'h1;
      end
    end
  end

  always_comb begin
    sk_lvl = master ? skm_q : sk_s2_q;
    rise   = master ? (skm_d & ~skm_q) : (sk_s2_q & ~sk_s3_q);
    fall   = master ? (~skm_d & skm_q) : (~sk_s2_q & sk_s3_q);
  end

  // Pin drive, output enables active low
  always_comb begin
    O_SHIFT_CLOCK_PIN      = skm_q;
    O_SHIFT_CLOCK_PIN_OE_N = ~master;
    O_SDO                  = sdo_w;
    // output floats unless enabled with pin four set
    O_SDO_OE_N             = ~(enabled && cfg_q[CFG_PIN4_BIT]);
    O_IRQ                  = irq_q;
  end

  ssp_shifter u_shift (
    .i_clk       (I_MCLK),
    .i_rst       (I_RST),
    .i_active    (active),
    .i_alt_phase (cfg_q[CFG_PIN6_BIT]),
    .i_rise      (rise),
    .i_fall      (fall),
    .i_sdi       (sdi_s2_q),
    .i_load      (load),
    .i_load_data (wd_q[7:0]),
    .o_data      (shift_data),
    .o_sdo       (sdo_w),
    .o_done      (done_pulse)
  );

  // AXI4-Lite slave next state
  always_comb begin
    aw_d  = aw_q;
    awa_d = awa_q;
    w_d   = w_q;
    wd_d  = wd_q;
    ws_d  = ws_q;
    bv_d  = bv_q;
    br_d  = br_q;
    rv_d  = rv_q;
    rd_d  = rd_q;
    rr_d  = rr_q;
    wr_go = 1'b0;
    // Address and data refused while a write answer is pending
    O_AWREADY = !aw_q && !bv_q;
    O_WREADY  = !w_q && !bv_q;
    O_ARREADY = !rv_q;
    if (I_AWVALID && O_AWREADY) begin
      aw_d  = 1'b1;
      awa_d = I_AWADDR;
    end
    if (I_WVALID && O_WREADY) begin
      w_d  = 1'b1;
      wd_d = I_WDATA;
      ws_d = I_WSTRB;
    end
    if (aw_q && w_q && !bv_q) begin
      wr_go = 1'b1;
      aw_d  = 1'b0;
      w_d   = 1'b0;
      bv_d  = 1'b1;
      br_d  = (awa_q[7:2] <= REG_PORTCFG_OFS[7:2]) ? RESP_OKAY : RESP_SLVERR;
    end
    if (bv_q && I_BREADY) begin
      bv_d = 1'b0;
    end
    if (I_ARVALID && O_ARREADY) begin
      rv_d = 1'b1;
      rr_d = RESP_OKAY;
      rd_d = 32'h0000_0000;
      unique case ({I_ARADDR[7:2], 2'b00})
        REG_CTRL_OFS:    rd_d[2:0] = ctrl_q;
        REG_STATUS_OFS:  rd_d[3:0] = {sk_lvl, done_q, ien_q, busy_q};
        REG_SHIFT_OFS:   rd_d[7:0] = shift_data;
        REG_PORTCFG_OFS: rd_d[6:4] = cfg_q;
        default:         rr_d = RESP_SLVERR;
      endcase
    end else if (rv_q && I_RREADY) begin
      rv_d = 1'b0;
    end
  end

  // Register writes and hardware updates
  always_comb begin
    ctrl_d = ctrl_q;
    cfg_d  = cfg_q;
    busy_d = busy_q;
    ien_d  = ien_q;
    done_d = done_q;
    irq_d  = 1'b0;
    // load only meaningful with clock low
    load = wr_go && ws_q[0] && awa_q[7:2] == REG_SHIFT_OFS[7:2];
    if (wr_go && ws_q[0]) begin
      if (awa_q[7:2] == REG_CTRL_OFS[7:2]) begin
        ctrl_d = wd_q[2:0];
      end
      if (awa_q[7:2] == REG_PORTCFG_OFS[7:2]) begin
        cfg_d = wd_q[6:4];
      end
      if (awa_q[7:2] == REG_STATUS_OFS[7:2]) begin
        busy_d = wd_q[STAT_BUSY_BIT];
        ien_d  = wd_q[STAT_IEN_BIT];
        if (wd_q[STAT_DONE_BIT]) done_d = 1'b0;
      end
    end
    // hardware clears busy after eight bits
    if (done_pulse) begin
      busy_d = 1'b0;
      done_d = 1'b1;
      irq_d  = ien_q;
    end
  end

  // State registers
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      ctrl_q <= CTRL_RESET;
      cfg_q  <= PORTCFG_RESET;
      busy_q <= 1'b0;
      ien_q  <= 1'b0;
      done_q <= 1'b0;
      irq_q  <= 1'b0;
      aw_q   <= 1'b0;
      awa_q  <= 8'h00;
      w_q    <= 1'b0;
      wd_q   <= 32'h0000_0000;
      ws_q   <= 4'h0;
      bv_q   <= 1'b0;
      br_q   <= RESP_OKAY;
      rv_q   <= 1'b0;
      rd_q   <= 32'h0000_0000;
      rr_q   <= RESP_OKAY;
      tc_q   <= 5'h00;
      hc_q   <= 3'h0;
      skm_q  <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      cfg_q  <= cfg_d;
      busy_q <= busy_d;
      ien_q  <= ien_d;
      done_q <= done_d;
      irq_q  <= irq_d;
      aw_q   <= aw_d;
      awa_q  <= awa_d;
      w_q    <= w_d;
      wd_q   <= wd_d;
      ws_q   <= ws_d;
      bv_q   <= bv_d;
      br_q   <= br_d;
      rv_q   <= rv_d;
      rd_q   <= rd_d;
      rr_q   <= rr_d;
      tc_q   <= tc_d;
      hc_q   <= hc_d;
      skm_q  <= skm_d;
    end
  end

  assign O_BVALID = bv_q;
  assign O_BRESP  = br_q;
  assign O_RVALID = rv_q;
  assign O_RDATA  = rd_q;
  assign O_RRESP  = rr_q;
endmodule : ssp_top
`default_nettype wire

/* sim/ssp_top_properties.sv */
// Checker: port timing of the serial shift port
`default_nettype none
module ssp_top_properties
  import ssp_pkg::*;
(
  // Clock, reset and bus
  input wire logic       I_MCLK,
  input wire logic       I_RST,
  input wire logic       I_AWVALID,
  input wire logic       O_AWREADY,
  input wire logic       I_WVALID,
  input wire logic       O_WREADY,
  input wire logic       O_BVALID,
  input wire logic [1:0] O_BRESP,
  input wire logic       I_ARVALID,
  input wire logic       O_ARREADY,
  input wire logic       O_RVALID,
  // Serial side
  input wire logic       O_SHIFT_CLOCK_PIN,
  input wire logic       O_SHIFT_CLOCK_PIN_OE_N,
  input wire logic       O_IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);
  // Shift clock shape and completion pulse
  property p_rise_master; $rose(O_SHIFT_CLOCK_PIN) |-> !O_SHIFT_CLOCK_PIN_OE_N; endproperty
  a_rise_master: assert property (p_rise_master)
    else $error("clock pulse while not master");
  property p_high_min; $rose(O_SHIFT_CLOCK_PIN) |-> O_SHIFT_CLOCK_PIN [*8]; endproperty
  a_high_min: assert property (p_high_min)
    else $error("shift clock high too short");
  property p_low_min; $fell(O_SHIFT_CLOCK_PIN) |-> !O_SHIFT_CLOCK_PIN [*8]; endproperty
  a_low_min: assert property (p_low_min)
    else $error("shift clock low too short");
  property p_irq_pulse; O_IRQ |=> !O_IRQ; endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("completion pulse too long");
  // Bus answers and refusals
  property p_r_answer; I_ARVALID && O_ARREADY |=> O_RVALID; endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read answer late");
  property p_b_answer; I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##[1:2] O_BVALID;
  endproperty
  a_b_answer: assert property (p_b_answer)
    else $error("write answer late");
  property p_aw_block; O_BVALID |-> !O_AWREADY; endproperty
  a_aw_block: assert property (p_aw_block)
    else $error("address taken while pending");
  property p_ar_block; O_RVALID |-> !O_ARREADY; endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read taken while pending");
  c_irq: cover property (O_IRQ);
  c_pulse: cover property ($rose(O_SHIFT_CLOCK_PIN));
  c_slverr: cover property (O_BVALID && O_BRESP == RESP_SLVERR);
endmodule : ssp_top_properties
bind ssp_top ssp_top_properties u_props (
  .I_MCLK, .I_RST, .I_AWVALID, .O_AWREADY, .I_WVALID, .O_WREADY, .O_BVALID,
  .O_BRESP, .I_ARVALID, .O_ARREADY, .O_RVALID, .O_SHIFT_CLOCK_PIN,
  .O_SHIFT_CLOCK_PIN_OE_N, .O_IRQ
);
`default_nettype wire

/* sim/ssp_peer.sv */
// Partner model: serial peripheral or controller on the far side
`default_nettype none
module ssp_peer (
  // Link pins
  input  wire logic i_sck,
  input  wire logic i_sdo,
  input  wire logic i_alt,
  output logic      o_sdi,
  output logic      o_sck
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  initial begin
    o_sck = 1'b0;
    o_sdi = 1'b0;
  end
  // Load word, normal phase shows first bit at once
  task automatic load(input logic [7:0] d);
    tx_q = d;
    if (!i_alt) begin
      o_sdi = tx_q[7];
      tx_q = {tx_q[6:0], 1'b0};
    end
  endtask : load
  // Rising edge: sample or drive by phase
  always @(posedge i_sck) begin
    if (i_alt) begin
      o_sdi = tx_q[7];
      tx_q = {tx_q[6:0], 1'b0};
    end else begin
      rx_q = {rx_q[6:0], i_sdo};
    end
  end
  // Falling edge: the other half
  always @(negedge i_sck) begin
    if (i_alt) begin
      rx_q = {rx_q[6:0], i_sdo};
    end else begin
      o_sdi = tx_q[7];
      tx_q = {tx_q[6:0], 1'b0};
    end
  end
  // eight pulses, clock still between frames
  task automatic frame();
    #7;
    repeat (8) begin
      #160 o_sck = 1'b1;
      #160 o_sck = 1'b0;
    end
    #160 o_sdi = ~o_sdi;
  endtask : frame
endmodule : ssp_peer
`default_nettype wire

/* sim/ssp_top_test.sv */
// Testbench: serial shift port against the partner model
`default_nettype none
module ssp_top_test
  import ssp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HC[4] = '{1, 2, 4, 4};
  logic        clk, rst, awv, wv, bready, arv, rready, alt, irq_seen;
  logic        awrdy, wrdy, bv, arrdy, rv, sck, sck_oe_n, sdo, sdo_oe_n, irq;
  logic        sdi, psck, skw, sdw;
  logic [1:0]  bresp, rresp;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  int          miscompares, n_tests, cyc;
  ssp_top DUT (
    .I_MCLK(clk), .I_RST(rst), .I_AWVALID(awv), .O_AWREADY(awrdy), .I_AWADDR(awaddr),
    .I_WVALID(wv), .O_WREADY(wrdy), .I_WDATA(wdata), .I_WSTRB(4'hF), .O_BVALID(bv),
    .I_BREADY(bready), .O_BRESP(bresp), .I_ARVALID(arv), .O_ARREADY(arrdy),
    .I_ARADDR(araddr), .O_RVALID(rv), .I_RREADY(rready),
    .O_RDATA(rdata), .O_RRESP(rresp), .I_SDI(sdi), .I_SHIFT_CLOCK_PIN(skw),
    .O_SHIFT_CLOCK_PIN(sck), .O_SHIFT_CLOCK_PIN_OE_N(sck_oe_n), .O_SDO(sdo),
    .O_SDO_OE_N(sdo_oe_n), .O_IRQ(irq)
  );
  ssp_peer u_peer (.i_sck(skw), .i_sdo(sdw), .i_alt(alt), .o_sdi(sdi), .o_sck(psck));
  // Shared clock wire, released data line inverted
  assign skw = sck_oe_n ? psck : sck;
  assign sdw = sdo_oe_n ? ~sdo : sdo;
  // Clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard and completion watch
  always @(posedge clk) begin
    cyc++;
    if (irq) irq_seen <= 1'b1;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata  <= d;
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv);
    bready <= 1'b0;
    chk(bresp, r);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [1:0] r, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arv    <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arrdy) arv <= 1'b0;
    end while (!rv);
    rready <= 1'b0;
    d = rdata;
    chk(rresp, r);
  endtask : axi_rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    axi_rd(a, RESP_OKAY, d);
    chk(d, e);
  endtask : rdc
  task automatic t_reset();
    logic [31:0] d;
    rdc(REG_CTRL_OFS, 32'h0000_0000);
    rdc(REG_PORTCFG_OFS, 32'h0000_0000);
    rdc(REG_STATUS_OFS, 32'h0000_0000);
    axi_rd(8'h10, RESP_SLVERR, d);
    chk(d, 32'h0000_0000);
    axi_wr(8'h10, 32'h0000_00FF, RESP_SLVERR);
    chk(sck_oe_n, 32'h0000_0001);
  endtask : t_reset
  task automatic t_master();
    int t;
    for (int r = 0; r < 4; r++) begin
      alt <= (r == 3);
      // data-out and clock pins set as outputs
      axi_wr(REG_PORTCFG_OFS, (r == 3) ? 32'h0000_0070 : 32'h0000_0030, RESP_OKAY);
      axi_wr(REG_CTRL_OFS, 32'h0000_0004 | 32'(r), RESP_OKAY);
      // shift register loaded only while clock rests low
      chk(sck, 32'h0000_0000);
      axi_wr(REG_SHIFT_OFS, 32'h0000_00A5 ^ 32'(r), RESP_OKAY);
      u_peer.load(8'h3C ^ 8'(r));
      irq_seen <= 1'b0;
      axi_wr(REG_STATUS_OFS, 32'h0000_0003, RESP_OKAY);
      t = 0;
      while (!sck) @(posedge clk);
      while (sck) begin
        @(posedge clk);
        t++;
      end
      chk(32'(t), 32'(INSTR_CYCLES * HC[r]));
      repeat (2000) if (!irq_seen) @(posedge clk);
      chk(irq_seen, 32'h0000_0001);
      rdc(REG_STATUS_OFS, 32'h0000_0006);
      rdc(REG_SHIFT_OFS, 32'h0000_003C ^ 32'(r));
      chk(u_peer.rx_q, 32'h0000_00A5 ^ 32'(r));
      axi_wr(REG_STATUS_OFS, 32'h0000_0004, RESP_OKAY);
    end
  endtask : t_master
  task automatic t_abort();
    axi_wr(REG_PORTCFG_OFS, 32'h0000_0020, RESP_OKAY);
    axi_wr(REG_CTRL_OFS, 32'h0000_0004, RESP_OKAY);
    irq_seen <= 1'b0;
    axi_wr(REG_STATUS_OFS, 32'h0000_0003, RESP_OKAY);
    while (!sck) @(posedge clk);
    while (sck) @(posedge clk);
    chk(sdo_oe_n, 32'h0000_0001);
    axi_wr(REG_STATUS_OFS, 32'h0000_0000, RESP_OKAY);
    repeat (200) @(posedge clk);
    chk({irq_seen, sck}, 32'h0000_0000);
    rdc(REG_STATUS_OFS, 32'h0000_0000);
    axi_wr(REG_CTRL_OFS, 32'h0000_0000, RESP_OKAY);
    axi_wr(REG_STATUS_OFS, 32'h0000_0003, RESP_OKAY);
    repeat (200) @(posedge clk);
    chk({irq_seen, sck, sck_oe_n}, 32'h0000_0001);
    axi_wr(REG_STATUS_OFS, 32'h0000_0000, RESP_OKAY);
  endtask : t_abort
  task automatic t_slave();
    alt <= 1'b0;
    axi_wr(REG_PORTCFG_OFS, 32'h0000_0010, RESP_OKAY);
    axi_wr(REG_CTRL_OFS, 32'h0000_0004, RESP_OKAY);
    axi_wr(REG_SHIFT_OFS, 32'h0000_005A, RESP_OKAY);
    u_peer.load(8'hC3);
    irq_seen <= 1'b0;
    axi_wr(REG_STATUS_OFS, 32'h0000_0001, RESP_OKAY);
    chk({sck_oe_n, sdo_oe_n}, 32'h0000_0002);
    rdc(REG_STATUS_OFS, 32'h0000_0001);
    u_peer.frame();
    repeat (20) @(posedge clk);
    chk(irq_seen, 32'h0000_0000);
    rdc(REG_STATUS_OFS, 32'h0000_0004);
    rdc(REG_SHIFT_OFS, 32'h0000_00C3);
    chk(u_peer.rx_q, 32'h0000_005A);
  endtask : t_slave
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    {rst, awv, wv, bready, arv, rready, alt, irq_seen} = 8'h80;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_master();
    t_abort();
    t_slave();
    end_of_test();
  end
endmodule : ssp_top_test
`default_nettype wire
